// ===== include/mcr_pkg.sv
// package for the mac configuration, transmit queue and receive status block
package mcr_pkg;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] MCR_OFF_CONFIG  = 8'h04;
    localparam logic [7:0] MCR_OFF_STATUS  = 8'h08;
    localparam logic [7:0] MCR_OFF_TX_ADDR = 8'h0c;
    localparam logic [7:0] MCR_OFF_TX_CTRL = 8'h10;
    localparam logic [7:0] MCR_OFF_TX_STAT = 8'h14;
    localparam logic [7:0] MCR_OFF_RX_QPTR = 8'h18;
    localparam logic [7:0] MCR_OFF_RX_STAT = 8'h20;
    localparam logic [7:0] MCR_OFF_CONTROL = 8'h00;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int MCR_CTL_UNLOCK   = 7;
    localparam int MCR_CTL_BACKP    = 8;
    localparam int MCR_CFG_SPEED    = 0;
    localparam int MCR_CFG_FDX      = 1;
    localparam int MCR_CFG_PROMISC  = 4;
    localparam int MCR_CFG_NOBCAST  = 5;
    localparam int MCR_CFG_MHASH    = 6;
    localparam int MCR_CFG_UHASH    = 7;
    localparam int MCR_CFG_LONG     = 8;
    localparam int MCR_CFG_DIV_LO   = 10;
    localparam int MCR_CFG_RETRY    = 12;
    localparam int MCR_CFG_RMII     = 13;
    localparam logic [31:0] MCR_CTL_MASK   = 32'h0000_0180;
    localparam logic [31:0] MCR_CFG_MASK   = 32'h0000_3df7;
    localparam logic [31:0] MCR_CFG_RESET  = 32'h0000_0800;
    localparam int MCR_TCR_NOFCS    = 15;
    localparam int MCR_LEN_W        = 11;
    localparam int MCR_TS_OVR       = 0;
    localparam int MCR_TS_COL       = 1;
    localparam int MCR_TS_RLE       = 2;
    localparam int MCR_TS_IDLE      = 3;
    localparam int MCR_TS_BNQ       = 4;
    localparam int MCR_TS_COMP      = 5;
    localparam int MCR_TS_UND       = 6;
    localparam int MCR_RS_BNA       = 0;
    localparam int MCR_RS_REC       = 1;
    localparam int MCR_RS_OVR       = 2;

    // ****************************************************************
    // frame limits and timing
    // ****************************************************************
    localparam logic [10:0] MCR_MAX_FCS      = 11'd1514;
    localparam logic [10:0] MCR_MAX_NOFCS    = 11'd1518;
    localparam logic [10:0] MCR_RX_MAX       = 11'd1518;
    localparam logic [10:0] MCR_RX_MAX_LONG  = 11'd1522;
    localparam logic [6:0]  MCR_JAM_BITS     = 7'd64;
    localparam logic [2:0]  MCR_FIFO_START   = 3'd2;
    localparam logic [1:0]  MCR_DIV_RESET    = 2'b10;

    // one queued transmit request
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [10:0] len;
        logic        nofcs;
    } mcr_txreq_s;

    // receive frame summary from the phy-side receiver
    typedef struct packed {
        logic        start;
        logic        done;
        logic [47:0] dest;
        logic [10:0] len;
        logic        crc_ok;
    } mcr_rxfrm_s;

    typedef enum logic [1:0] {MCR_TX_IDLE, MCR_TX_WAIT, MCR_TX_SEND} mcr_txst_e;

    // whole state of the block except the pin synchronisers
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] cfg;
        mcr_txreq_s  pend;
        mcr_txreq_s  cur;
        mcr_txst_e   txst;
        logic [6:0]  tstat;
        logic [2:0]  rstat;
        logic [31:0] rqptr;
        logic [31:0] rdata;
        logic [5:0]  mdc_cnt;
        logic        mdc;
        logic [6:0]  jam_cnt;
        logic        rx_busy;
        logic        rx_keep;
    } mcr_state_s;

endpackage

// ===== verif/mcr_phy_model.sv
// behavioural phy model: receive frames, carrier sense, collision and mdio level
`timescale 1ns/10ps
module mcr_phy_model
    import mcr_pkg::*;
#(
    parameter int FRAME_CYC = 80
)
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        send_in,
    input  wire logic [47:0] dest_in,
    input  wire logic [10:0] len_in,
    input  wire logic        jam_in,
    output mcr_rxfrm_s       rx_frame_out,
    output logic             crs_out,
    output logic             col_out,
    output logic             mdio_out
);
    int cnt;

    // mdio is pulled up and nobody drives it outside management frames
    assign mdio_out = 1'b1;
    // a mac jamming into a live frame is seen by the phy as a collision
    assign col_out = crs_out & jam_in;

    // start pulse, carrier for FRAME_CYC cycles, done pulse, then stale fields inverted
    always_ff @(posedge clk_in) begin
        rx_frame_out.start <= 1'b0;
        rx_frame_out.done  <= 1'b0;
        if (sys_rst_in) begin
            rx_frame_out <= '0;
            crs_out      <= 1'b0;
            cnt          <= 0;
        end else if (send_in) begin
            rx_frame_out.start  <= 1'b1;
            rx_frame_out.dest   <= dest_in;
            rx_frame_out.len    <= len_in;
            rx_frame_out.crc_ok <= 1'b1;
            crs_out             <= 1'b1;
            cnt                 <= FRAME_CYC;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                rx_frame_out.done <= 1'b1;
                crs_out           <= 1'b0;
            end
        end else if (rx_frame_out.done) begin
            // summary no longer held: show garbage, not the last value
            rx_frame_out.dest <= ~rx_frame_out.dest;
            rx_frame_out.len  <= ~rx_frame_out.len;
        end
    end
endmodule

// ===== verif/mcr_regs_tb.sv
// self-checking bench for the mac register, transmit queue and receive status block
`timescale 1ns/10ps
module mcr_regs_tb;
    import mcr_pkg::*;
    typedef struct {logic [31:0] ctl, cfg; logic [47:0] dest; logic [10:0] len; int acc, jam;}
        mcr_tbrow_s;
    // ****************************************************************
    // signals and table
    // ****************************************************************
    logic        clk_in = 0;
    logic        sys_rst_in = 1;
    logic [7:0]  addr = 0;
    logic [31:0] wdata = 0;
    logic        wr = 0, rd = 0, busy = 1, owned = 0, send = 0;
    logic [4:0]  ev = 0;
    logic [2:0]  fifo = 0;
    logic [47:0] dest = 0;
    logic [10:0] flen = 0;
    logic [31:0] rdata_out;
    mcr_rxfrm_s  rx_frame;
    mcr_txreq_s  tx_req_out;
    logic        crs, col, mdio, tx_start_out, bad_crc, col_hon, rx_dtx, jam_out;
    logic        slot_gap_out, rmii_mode_out, mdc_out, rx_accept_out, stats_wr_en_out, p;
    int          n_fail = 0, comparisons = 0, cycles = 0, na, nj, nh, k;
    mcr_tbrow_s  rows[10] = '{
        '{32'h0, 32'h3080, 48'h04, 11'd64, 1, 0}, '{32'hffffffff, 32'h12, 48'h02, 11'd64, 1, 0},
        '{32'h100, 32'h10, 48'h02, 11'd64, 1, 64}, '{32'h0, 32'h20, '1, 11'd64, 0, 0},
        '{32'h0, 32'h0, '1, 11'd64, 1, 0}, '{32'h0, 32'h40, 48'h01, 11'd64, 1, 0},
        '{32'h0, 32'h0, 48'h01, 11'd64, 0, 0}, '{32'h0, 32'h10, 48'h02, 11'd1519, 0, 0},
        '{32'h0, 32'h110, 48'h02, 11'd1522, 1, 0}, '{'1, '1, 48'h02, 11'd1523, 0, 0}};

    mcr_regs i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out), .mdio_pin_in(mdio), .mgmt_busy_in(busy),
        .col_pin_in(col), .crs_pin_in(crs), .fifo_words_in(fifo), .dma_starve_in(ev[0]),
        .retry_limit_in(ev[1]), .tx_done_in(ev[2]), .tx_cur_addr_in(32'h1234_5600),
        .rx_frame_in(rx_frame), .hash_table_in('1), .station_addr_in(48'h0000_0000_0002),
        .rx_buf_owned_in(owned), .rx_stored_in(ev[3]), .rx_overrun_in(ev[4]),
        .rx_cur_ptr_in(32'h0000_8840), .tx_start_out(tx_start_out), .tx_req_out(tx_req_out),
        .tx_force_bad_crc_out(bad_crc), .tx_col_honour_out(col_hon),
        .rx_during_tx_ok_out(rx_dtx), .jam_out(jam_out), .slot_gap_out(slot_gap_out),
        .rmii_mode_out(rmii_mode_out), .mdc_out(mdc_out), .rx_accept_out(rx_accept_out),
        .stats_wr_en_out(stats_wr_en_out));

    mcr_phy_model i_phy (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .send_in(send),
        .dest_in(dest), .len_in(flen), .jam_in(jam_out), .rx_frame_out(rx_frame),
        .crs_out(crs), .col_out(col), .mdio_out(mdio));

    // clock and hang guard; the run needs about 1700 cycles
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            stop_test;
        end
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task chk(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task do_reset;
        @(posedge clk_in);
        sys_rst_in <= 1;
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 0;
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1;
        @(posedge clk_in);
        wr <= 0;
    endtask
    // read data only stands in the cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1;
        @(posedge clk_in);
        rd <= 0;
        #1 chk(rdata_out & m, e);
    endtask
    task pulse(input logic [4:0] v);
        @(posedge clk_in);
        ev <= v;
        @(posedge clk_in);
        ev <= 0;
    endtask
    // one received frame; counts accept pulses, jam cycles and collision-honour cycles
    task frame(input logic [47:0] d, input logic [10:0] l);
        @(posedge clk_in);
        dest <= d;
        flen <= l;
        send <= 1;
        @(posedge clk_in);
        send <= 0;
        na = 0;
        nj = 0;
        nh = 0;
        repeat (120) begin
            @(posedge clk_in);
            #1 na += (rx_accept_out === 1'b1);
            nj += (jam_out === 1'b1);
            nh += (col_hon === 1'b1);
        end
    endtask
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        do_reset;
        foreach (rows[i]) begin
            wr_reg(MCR_OFF_CONTROL, rows[i].ctl);
            wr_reg(MCR_OFF_CONFIG, rows[i].cfg);
            rd_chk(MCR_OFF_CONFIG, '1, rows[i].cfg & MCR_CFG_MASK);
            rd_chk(MCR_OFF_CONTROL, '1, rows[i].ctl & MCR_CTL_MASK);
            chk({rmii_mode_out, slot_gap_out, rx_dtx, stats_wr_en_out}, {rows[i].cfg[13],
                rows[i].cfg[12], rows[i].cfg[1], rows[i].ctl[7]});
            frame(rows[i].dest, rows[i].len);
            chk(na, rows[i].acc);
            chk(nj, rows[i].jam);
            chk(nh != 0, !rows[i].cfg[MCR_CFG_FDX]);
        end
        // collision from the jam row, then retry limit, both cleared by one
        rd_chk(MCR_OFF_TX_STAT, 32'h2, 32'h2);
        pulse(5'h02);
        rd_chk(MCR_OFF_TX_STAT, 32'h6, 32'h6);
        wr_reg(MCR_OFF_TX_STAT, 32'h6);
        rd_chk(MCR_OFF_TX_STAT, 32'h6, 32'h0);
        // divider codes give half periods of 4, 8, 16 and 32 cycles
        for (int c = 0; c < 4; c++) begin
            wr_reg(MCR_OFF_CONFIG, c << MCR_CFG_DIV_LO);
            repeat (3) begin
                p = mdc_out;
                k = 0;
                while (mdc_out === p && k < 100) begin
                    @(posedge clk_in);
                    #1 k++;
                end
            end
            chk(k, 4 << c);
        end
        // reset in mid-run restores the documented defaults
        do_reset;
        rd_chk(MCR_OFF_CONFIG, '1, 32'h800);
        rd_chk(MCR_OFF_STATUS, '1, 32'h6);
        rd_chk(MCR_OFF_TX_STAT, '1, 32'h18);
        rd_chk(8'h1c, '1, 32'h0);
        busy <= 0;
        rd_chk(MCR_OFF_STATUS, '1, 32'h2);
        // first frame waits for two fifo words, second is queued behind it
        fifo <= 3'd1;
        wr_reg(MCR_OFF_TX_ADDR, 32'h100);
        wr_reg(MCR_OFF_TX_CTRL, 32'h40);
        rd_chk(MCR_OFF_TX_STAT, 32'h18, 32'h10);
        chk(tx_req_out, {1'b1, 32'h100, 11'h40, 1'b0});
        chk(tx_start_out, 0);
        @(posedge clk_in);
        fifo <= 3'd2;
        #1 chk(tx_start_out, 1);
        rd_chk(MCR_OFF_TX_CTRL, '1, 32'h40);
        rd_chk(MCR_OFF_TX_ADDR, '1, 32'h1234_5600);
        wr_reg(MCR_OFF_TX_ADDR, 32'h203);
        wr_reg(MCR_OFF_TX_CTRL, 32'h85ee);
        rd_chk(MCR_OFF_TX_STAT, 32'h19, 32'h0);
        wr_reg(MCR_OFF_TX_ADDR, 32'h300);
        rd_chk(MCR_OFF_TX_STAT, 32'h1, 32'h1);
        wr_reg(MCR_OFF_TX_STAT, 32'h1);
        rd_chk(MCR_OFF_TX_STAT, 32'h1, 32'h0);
        pulse(5'h01);
        rd_chk(MCR_OFF_TX_STAT, 32'h40, 32'h40);
        chk(bad_crc, 1);
        wr_reg(MCR_OFF_TX_STAT, 32'h40);
        pulse(5'h04);
        rd_chk(MCR_OFF_TX_STAT, 32'h60, 32'h20);
        chk(tx_req_out, {1'b1, 32'h203, 11'd1518, 1'b1});
        chk(bad_crc, 0);
        rd_chk(MCR_OFF_TX_CTRL, '1, 32'h85ee);
        fork
            pulse(5'h04);
            wr_reg(MCR_OFF_TX_STAT, 32'h20);
        join
        rd_chk(MCR_OFF_TX_STAT, 32'h38, 32'h38);
        wr_reg(MCR_OFF_TX_ADDR, 32'h400);
        wr_reg(MCR_OFF_TX_CTRL, 32'd1515);
        rd_chk(MCR_OFF_TX_CTRL, '1, 32'd1515);
        chk(bad_crc, 1);
        // receive side: owned buffer, stored frame and overrun, all cleared by one
        wr_reg(MCR_OFF_RX_QPTR, 32'h1003);
        rd_chk(MCR_OFF_RX_QPTR, '1, 32'h0000_8840);
        owned <= 1;
        frame(48'h02, 11'd64);
        chk(na, 1);
        owned <= 0;
        pulse(5'h18);
        rd_chk(MCR_OFF_RX_STAT, '1, 32'h7);
        wr_reg(MCR_OFF_RX_STAT, 32'h7);
        rd_chk(MCR_OFF_RX_STAT, '1, 32'h0);
        stop_test;
    end
endmodule

// ===== verilog/mcr_regs.sv
// register file, transmit queue and receive status logic of a 10/100 mac
`timescale 1ns/10ps

// Operation
// [RL1] unlock bit lets software write statistics counters
// [RL2] back pressure in half duplex jams 64 bits
// [RL3] speed bit is indication only
// [RL4] full duplex ignores collision and carrier sense
// [RL5] promiscuous accepts all, broadcast rejection drops broadcasts; code drops bad crc and oversize even in promiscuous mode
// [RL6] hash index from crc selects hash bit
// [RL7] accept 1518 bytes, 1522 with long enable
// [RL8] management clock divides by 8/16/32/64, reset 32
// [RL9] retry test forces one slot gap
// [RL10] reduced interface select picks rmii or mii
// [RL11] status shows mdio level and management busy
// [RL12] tx address reads back buffer in use
// [RL13] non-zero length starts transmit, oversize flagged
// [RL14] software writes address before length
// [RL15] start after two fifo words, length stable
// [RL16] skip fcs append sends length as given
// [RL17] write while queue full sets overrun
// [RL18] collision, done, retry flags clear on one
// [RL19] idle and queue-free flags follow queue
// [RL20] dma starvation sets underrun, forces bad crc
// [RL21] rx queue pointer word aligned, reads current
// [RL22] no-buffer and frame-stored flags clear on one
// [RL23] unassigned bits read zero, ignore writes
module mcr_regs
    import mcr_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic        mdio_pin_in,
    input  wire logic        mgmt_busy_in,
    input  wire logic        col_pin_in,
    input  wire logic        crs_pin_in,
    input  wire logic [2:0]  fifo_words_in,
    input  wire logic        dma_starve_in,
    input  wire logic        retry_limit_in,
    input  wire logic        tx_done_in,
    input  wire logic [31:0] tx_cur_addr_in,
    input  wire mcr_rxfrm_s  rx_frame_in,
    input  wire logic [63:0] hash_table_in,
    input  wire logic [47:0] station_addr_in,
    input  wire logic        rx_buf_owned_in,
    input  wire logic        rx_stored_in,
    input  wire logic        rx_overrun_in,
    input  wire logic [31:0] rx_cur_ptr_in,
    output logic             tx_start_out,
    output mcr_txreq_s       tx_req_out,
    output logic             tx_force_bad_crc_out,
    output logic             tx_col_honour_out,
    output logic             rx_during_tx_ok_out,
    output logic             jam_out,
    output logic             slot_gap_out,
    output logic             rmii_mode_out,
    output logic             mdc_out,
    output logic             rx_accept_out,
    output logic             stats_wr_en_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // six-bit hash index: low six bits of the crc32 of the destination
    function automatic logic [5:0] hash_idx(input logic [47:0] da);
        logic [31:0] crc;
        crc = 32'hffff_ffff;
        for (int i = 0; i < 48; i++) begin
            if (crc[0] ^ da[i]) begin
                crc = (crc >> 1) ^ 32'hedb8_8320;
            end else begin
                crc = crc >> 1;
            end
        end
        return crc[5:0];
    endfunction

    // half period of the management clock in master clock cycles
    function automatic logic [5:0] mdc_half(input logic [1:0] code);
        return 6'(6'h04 << code);
    endfunction

    // ****************************************************************
    // synchronisers for pins
    // ****************************************************************
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    always_ff @(posedge clk_in) begin
        pin_s1_r <= {crs_pin_in, col_pin_in, mdio_pin_in};
        pin_s2_r <= pin_s1_r;
    end
    logic mdio_s;
    logic col_s;
    logic crs_s;
    assign mdio_s = pin_s2_r[0];
    assign col_s  = pin_s2_r[1];
    assign crs_s  = pin_s2_r[2];

    mcr_state_s st_r;
    mcr_state_s st_nxt;

    // ****************************************************************
    // combinational next state
    // ****************************************************************
    logic wr_ctl;
    logic wr_cfg;
    logic wr_tar;
    logic wr_tcr;
    logic wr_tsr;
    logic wr_rqp;
    logic wr_rsr;
    logic queue_free;
    logic fdx;
    logic [10:0] rx_limit;
    logic is_bcast;
    logic is_mcast;
    logic hash_hit;

    assign wr_ctl = wr_in && addr_in == MCR_OFF_CONTROL;
    assign wr_cfg = wr_in && addr_in == MCR_OFF_CONFIG;
    assign wr_tar = wr_in && addr_in == MCR_OFF_TX_ADDR;
    assign wr_tcr = wr_in && addr_in == MCR_OFF_TX_CTRL;
    assign wr_tsr = wr_in && addr_in == MCR_OFF_TX_STAT;
    assign wr_rqp = wr_in && addr_in == MCR_OFF_RX_QPTR;
    assign wr_rsr = wr_in && addr_in == MCR_OFF_RX_STAT;
    assign fdx    = st_r.cfg[MCR_CFG_FDX];
    // queue free unless one frame waits while another transmits
    assign queue_free = !(st_r.pend.valid && st_r.cur.valid); // RL19
    assign rx_limit = st_r.cfg[MCR_CFG_LONG] ? MCR_RX_MAX_LONG : MCR_RX_MAX; // RL7
    assign is_bcast = &rx_frame_in.dest;
    assign is_mcast = rx_frame_in.dest[0];
    assign hash_hit = hash_table_in[hash_idx(rx_frame_in.dest)];

    always_comb begin
        logic accept;
        logic [6:0] ts_set;
        logic [2:0] rs_set;
        accept = 1'b0;
        ts_set = 7'h00;
        rs_set = 3'h0;
        st_nxt = st_r;

        // control and configuration writes keep only assigned bits
        if (wr_ctl) begin
            st_nxt.ctl = wdata_in & MCR_CTL_MASK; // RL23
        end
        if (wr_cfg) begin
            st_nxt.cfg = wdata_in & MCR_CFG_MASK; // RL23
        end

        // transmit queue: address first, then length queues the frame
        if (wr_tar || wr_tcr) begin
            if (!queue_free) begin
                ts_set[MCR_TS_OVR] = 1'b1; // RL17
            end
        end
        if (wr_tar && queue_free) begin
            st_nxt.pend.addr = wdata_in; // RL14
        end
        if (wr_tcr && queue_free && wdata_in[MCR_LEN_W-1:0] != 11'd0) begin
            st_nxt.pend.len   = wdata_in[MCR_LEN_W-1:0]; // RL13
            st_nxt.pend.nofcs = wdata_in[MCR_TCR_NOFCS]; // RL16
            st_nxt.pend.valid = 1'b1;
        end

        // promote pending request once the current frame is done
        case (st_r.txst)
            MCR_TX_IDLE: begin
                if (st_r.pend.valid) begin
                    st_nxt.cur        = st_r.pend;
                    st_nxt.pend.valid = 1'b0;
                    st_nxt.txst       = MCR_TX_WAIT;
                end
            end
            MCR_TX_WAIT: begin
                if (fifo_words_in >= MCR_FIFO_START) begin
                    st_nxt.txst = MCR_TX_SEND; // RL15
                end
            end
            MCR_TX_SEND: begin
                if (tx_done_in) begin
                    ts_set[MCR_TS_COMP] = 1'b1; // RL18
                    st_nxt.cur.valid    = 1'b0;
                    st_nxt.txst         = MCR_TX_IDLE;
                end
                if (dma_starve_in) begin
                    ts_set[MCR_TS_UND] = 1'b1; // RL20
                end
            end
            default: begin
                st_nxt.txst = MCR_TX_IDLE;
            end
        endcase

        // collision is ignored in full duplex
        if (col_s && !fdx) begin
            ts_set[MCR_TS_COL] = 1'b1; // RL4 RL18
        end
        if (retry_limit_in) begin
            ts_set[MCR_TS_RLE] = 1'b1; // RL18
        end

        // sticky transmit flags: set wins over write-one clear
        begin
            logic [6:0] clr;
            clr = wr_tsr ? (wdata_in[6:0] & 7'h67) : 7'h00;
            st_nxt.tstat = (st_r.tstat & ~clr) | ts_set; // RL18
        end

        // receive address filter on frame completion
        if (rx_frame_in.done) begin
            if (st_r.cfg[MCR_CFG_PROMISC]) begin
                accept = 1'b1; // RL5
            end else if (is_bcast) begin
                accept = !st_r.cfg[MCR_CFG_NOBCAST]; // RL5
            end else if (is_mcast) begin
                accept = st_r.cfg[MCR_CFG_MHASH] && hash_hit; // RL6
            end else begin
                accept = rx_frame_in.dest == station_addr_in
                      || (st_r.cfg[MCR_CFG_UHASH] && hash_hit); // RL6
            end
            accept = accept && rx_frame_in.crc_ok && rx_frame_in.len <= rx_limit; // RL7
        end
        st_nxt.rx_keep = accept;

        // receive dma buffer lookup retried at every frame start
        if (rx_frame_in.start && rx_buf_owned_in) begin
            rs_set[MCR_RS_BNA] = 1'b1; // RL22
        end
        if (rx_stored_in) begin
            rs_set[MCR_RS_REC] = 1'b1; // RL22
        end
        if (rx_overrun_in) begin
            rs_set[MCR_RS_OVR] = 1'b1;
        end
        begin
            logic [2:0] rclr;
            rclr = wr_rsr ? wdata_in[2:0] : 3'h0;
            st_nxt.rstat = (st_r.rstat & ~rclr) | rs_set; // RL22
        end

        // rx pointer forced to word alignment; otherwise tracks dma
        if (wr_rqp) begin
            st_nxt.rqptr = {wdata_in[31:2], 2'b00}; // RL21
        end else begin
            st_nxt.rqptr = {rx_cur_ptr_in[31:2], 2'b00}; // RL21
        end

        // back pressure: jam 64 bits on each received frame in half duplex
        if (st_r.jam_cnt != 7'd0) begin
            st_nxt.jam_cnt = st_r.jam_cnt - 7'd1;
        end else if (rx_frame_in.start && st_r.ctl[MCR_CTL_BACKP] && !fdx) begin
            st_nxt.jam_cnt = MCR_JAM_BITS; // RL2
        end

        // management clock divider
        if (st_r.mdc_cnt >= mdc_half(st_r.cfg[MCR_CFG_DIV_LO +: 2]) - 6'd1) begin
            st_nxt.mdc_cnt = 6'd0;
            st_nxt.mdc     = !st_r.mdc; // RL8
        end else begin
            st_nxt.mdc_cnt = st_r.mdc_cnt + 6'd1;
        end

        // read data, one cycle after the strobe
        st_nxt.rdata = 32'h0;
        if (rd_in) begin
            case (addr_in)
                MCR_OFF_CONTROL: st_nxt.rdata = st_r.ctl;
                MCR_OFF_CONFIG:  st_nxt.rdata = st_r.cfg; // RL3
                MCR_OFF_STATUS:  st_nxt.rdata = {29'h0, mgmt_busy_in, mdio_s, 1'b0}; // RL11
                MCR_OFF_TX_ADDR: begin
                    st_nxt.rdata = st_r.cur.valid ? tx_cur_addr_in : st_r.pend.addr; // RL12
                end
                MCR_OFF_TX_CTRL: begin
                    st_nxt.rdata = {16'h0, st_r.cur.nofcs, 4'h0, st_r.cur.len}; // RL15 RL16
                end
                MCR_OFF_TX_STAT: begin
                    st_nxt.rdata = {25'h0, st_r.tstat[6:5], queue_free,
                                    !st_r.pend.valid && !st_r.cur.valid,
                                    st_r.tstat[2:0]}; // RL19
                end
                MCR_OFF_RX_QPTR: st_nxt.rdata = st_r.rqptr; // RL21
                MCR_OFF_RX_STAT: st_nxt.rdata = {29'h0, st_r.rstat};
                default:         st_nxt.rdata = 32'h0; // RL23
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r         <= '0;
            st_r.cfg     <= MCR_CFG_RESET; // RL8
            st_r.txst    <= MCR_TX_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    logic oversize;
    assign oversize = st_r.cur.len > (st_r.cur.nofcs ? MCR_MAX_NOFCS : MCR_MAX_FCS); // RL13
    assign rdata_out            = st_r.rdata;
    assign tx_start_out         = st_r.txst == MCR_TX_WAIT && fifo_words_in >= MCR_FIFO_START;
    assign tx_req_out           = st_r.cur;
    assign tx_force_bad_crc_out = st_r.tstat[MCR_TS_UND] || oversize; // RL20
    assign tx_col_honour_out    = !fdx && (col_s || crs_s); // RL4
    assign rx_during_tx_ok_out  = fdx; // RL4
    assign jam_out              = st_r.jam_cnt != 7'd0; // RL2
    assign slot_gap_out         = st_r.cfg[MCR_CFG_RETRY]; // RL9
    assign rmii_mode_out        = st_r.cfg[MCR_CFG_RMII]; // RL10
    assign mdc_out              = st_r.mdc;
    assign rx_accept_out        = st_r.rx_keep;
    assign stats_wr_en_out      = st_r.ctl[MCR_CTL_UNLOCK]; // RL1

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    ovr_on_full_a: assert property ((wr_tar && !queue_free) |=> st_r.tstat[MCR_TS_OVR]) // RL17
        else $error("overrun not flagged");
    set_beats_clr_a: assert property ((tx_done_in && st_r.txst == MCR_TX_SEND && wr_tsr) // RL18
        |=> st_r.tstat[MCR_TS_COMP])
        else $error("complete flag lost on clear");
    fdx_no_col_a: assert property (fdx |-> !tx_col_honour_out) // RL4
        else $error("collision honoured in full duplex");
    jam_len_a: assert property ($rose(jam_out) |-> jam_out [*8]) // RL2
        else $error("jam too short");
    start_words_a: assert property (tx_start_out |-> fifo_words_in >= 3'd2) // RL15
        else $error("start before two words");
    rqp_align_a: assert property (wr_rqp |=> st_r.rqptr[1:0] == 2'b00) // RL21
        else $error("queue pointer not aligned");
    bna_set_a: assert property ((rx_frame_in.start && rx_buf_owned_in) |=> st_r.rstat[0]) // RL22
        else $error("no-buffer flag missing");
    mdc_period_a: assert property ((st_r.cfg[11:10] == 2'b00 && $changed(mdc_out) // RL8
        && !wr_cfg) |=> !$changed(mdc_out) [*3])
        else $error("management clock too fast");
    cfg_mask_a: assert property (wr_cfg |=> st_r.cfg[31:14] == 18'h0) // RL23
        else $error("reserved config bits stored");
    len_queue_a: assert property ((wr_tcr && queue_free && wdata_in[10:0] != 11'd0) // RL13
        |=> st_r.pend.valid || st_r.cur.valid)
        else $error("length write did not queue");

    tx_frame_c: cover property (tx_start_out ##[1:200] tx_done_in);
    queue_two_c: cover property (!queue_free);
    rx_accept_c: cover property (rx_accept_out);
    jam_c: cover property ($rose(jam_out));

endmodule
